// ---- core/dart_consts.svh ----
// Constants of the scan-driven delay and retentive timer block
// Assumes a 100 MHz core clock; included by name by the timebase and timer design files
`ifndef DART_CONSTS_SVH
`define DART_CONSTS_SVH

// ----------------------------------------------------------------
// Element layout
// ----------------------------------------------------------------
`define DART_BIT_ACTIVE      15
`define DART_BIT_RUNNING     14
`define DART_BIT_COMPLETE    13
`define DART_COUNT_MAX       16'h7FFF
`define DART_COUNT_ZERO      16'h0000
`define DART_SIGN_BIT        15

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DART_CLK_NS          10
`define DART_FINE_BASE_NS    10000000
`define DART_COARSE_BASE_NS  1000000000
`define DART_FINE_CYCLES     (`DART_FINE_BASE_NS / `DART_CLK_NS)
`define DART_COARSE_CYCLES   (`DART_COARSE_BASE_NS / `DART_CLK_NS)
`define DART_PEND_ONE        8'h01
`define DART_PEND_ZERO       8'h00

`endif

// ---- core/dart_pkg.sv ----
// Types shared by the timer block files
// Assumes dart_consts.svh for the constants
package dart_pkg;

   // Timer behaviour of an element
   typedef enum logic [1:0]
   {
      DART_ON_DELAY   = 2'b00,
      DART_OFF_DELAY  = 2'b01,
      DART_RETENTIVE  = 2'b10
   } dart_behav_type;

   // Controller operating mode
   typedef enum logic [1:0]
   {
      DART_EXECUTE    = 2'b00,
      DART_TRIAL      = 2'b01,
      DART_EDIT       = 2'b10,
      DART_FAULT_HALT = 2'b11
   } dart_mode_type;

endpackage

// ---- core/dart_tick_if.sv ----
// Interval ticks passed from the timebase to the timer element
// Assumes one core clock shared by both ends
`timescale 1ns/100ps
interface dart_tick_if;
   logic fineTick;
   logic coarseTick;

   modport source (output fineTick, output coarseTick);
   modport sink   (input  fineTick, input  coarseTick);
endinterface

// ---- core/dart_timebase.sv ----
// Free running timebase: one-cycle ticks every 10 ms and every 1 s
// Assumes a 100 MHz core clock and synchronous active high reset
`timescale 1ns/100ps
`include "dart_consts.svh"
module dart_timebase #(
   parameter int FINE_CYCLES   = `DART_FINE_CYCLES,
   parameter int COARSE_CYCLES = `DART_COARSE_CYCLES
)(
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   reset,
   // Ticks
   dart_tick_if.source ticks
);

   typedef struct packed
   {
      logic [19:0] fineCnt;
      logic [6:0]  coarseCnt;
      logic        fine;
      logic        coarse;
   } dart_tb_state_type;

   dart_tb_state_type st;
   dart_tb_state_type next_st;

   // Coarse tick counts fine ticks so both stay aligned
   always_comb
   begin
      next_st = st;
      next_st.fine = 1'b0;
      next_st.coarse = 1'b0;
      if (st.fineCnt == 20'(FINE_CYCLES - 1))
      begin
         next_st.fineCnt = 20'h00000;
         next_st.fine = 1'b1;
         if (st.coarseCnt == 7'(COARSE_CYCLES / FINE_CYCLES - 1))
         begin
            next_st.coarseCnt = 7'h00;
            next_st.coarse = 1'b1;
         end
         else
            next_st.coarseCnt = st.coarseCnt + 7'h01;
      end
      else
         next_st.fineCnt = st.fineCnt + 20'h00001;
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign ticks.fineTick = st.fine;
   assign ticks.coarseTick = st.coarse;

endmodule

// ---- core/dart_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
// Assumes asynchronous inputs and one core clock
`timescale 1ns/100ps
module dart_sync #(
   parameter int WIDTH = 1
)(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   // Pin side and clean side
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] cleanOut
);

   typedef struct packed
   {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] clean;
   } dart_sync_state_type;

   dart_sync_state_type st;
   dart_sync_state_type next_st;

   // A change counts once second and third stages agree
   always_comb
   begin
      next_st = st;
      next_st.s1 = pinIn;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++)
         if (st.s2[i] == st.s3[i])
            next_st.clean[i] = st.s3[i];
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign cleanOut = st.clean;

endmodule

// ---- core/dart_timer.sv ----
// Scan-driven timer element: on-delay, off-delay and retentive behaviour
// Assumes the controlling program presents rung and clear once per scan strobe
//
// Contract
// - On-delay counts while rung true, clears when false
// - Timebase per element: 0.01 s or 1.0 s
// - Counts 0..32767; negative value raises runtime error
// - Control word bits 15,14,13 then target, elapsed
// - On-delay complete when elapsed reaches target
// - Active follows rung; in on-delay and retentive only while zone active
// - Running while rung true and below target
// - On-delay interrupted keeps flags and count
// - On-delay resume while running clears count; flags follow rung
// - Off-delay counts while rung false, clears on true
// - Off-delay complete set while true, cleared when reached
// - Off-delay running while false and below target
// - Off-delay interrupted keeps flags and count
// - Off-delay resume: running cleared, rung decides rest
// - Clear zeroes flags and count; not for off-delay
// - Off-delay keeps timing in inactive control zone
// - Retentive keeps count across false rung, modes, faults
// - Retentive complete stays until clear command
// - Retentive interrupted keeps flags and count
// - Retentive resume: true continues, false clears active and running, keeps complete
`timescale 1ns/100ps
`include "dart_consts.svh"
module dart_timer #(
   parameter int FINE_CYCLES   = `DART_FINE_CYCLES,
   parameter int COARSE_CYCLES = `DART_COARSE_CYCLES
)(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   // Controller mode, from a pin
   input  wire dart_pkg::dart_mode_type ctrlMode,
   input  wire logic                   powerGood,
   // Element configuration
   input  wire dart_pkg::dart_behav_type behaviour,
   input  wire logic                   coarseBase,
   input  wire logic [15:0]            targetCount,
   // Scan interface from the controlling program
   input  wire logic                   scanStrobe,
   input  wire logic                   rungTrue,
   input  wire logic                   zoneActive,
   input  wire logic                   clearCommand,
   // Element state
   output logic [15:0]                 controlWord,
   output logic [15:0]                 targetWord,
   output logic [15:0]                 elapsedCount,
   output logic                        runtimeError
);

   // ----------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------
   logic [2:0] pinRaw;
   logic [2:0] pinClean;
   logic       powerOk;
   logic       modeRunRaw;
   logic       modeRun;

   // Mode and power arrive from outside the clock domain
   assign modeRunRaw = (ctrlMode == dart_pkg::DART_EXECUTE) || (ctrlMode == dart_pkg::DART_TRIAL);
   assign pinRaw = {modeRunRaw, powerGood, 1'b0};

   dart_sync #(
      .WIDTH (3)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .pinIn    (pinRaw),
      .cleanOut (pinClean)
   );

   assign powerOk = pinClean[1];
   assign modeRun = pinClean[2] && powerOk;

   dart_tick_if tickBus ();

   dart_timebase #(
      .FINE_CYCLES   (FINE_CYCLES),
      .COARSE_CYCLES (COARSE_CYCLES)
   ) u_timebase (
      .core_clk (core_clk),
      .reset    (reset),
      .ticks    (tickBus.source)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic        active;
      logic        running;
      logic        complete;
      logic [15:0] elapsed;
      logic [7:0]  pending;
      logic        wasRun;
      logic        resumed;
      logic        rungPrev;
      logic        error;
   } dart_timer_state_type;

   dart_timer_state_type st;
   dart_timer_state_type next_st;

   // Saturating add of pending intervals, capped at the target
   function automatic logic [15:0] addCapped(input logic [15:0] acc,
                                             input logic [7:0]  add,
                                             input logic [15:0] lim);
      logic [16:0] sum;
      sum = {1'b0, acc} + {9'h000, add};
      if (sum >= {1'b0, lim})
         addCapped = lim;
      else
         addCapped = sum[15:0];
   endfunction

   // Negative word check
   function automatic logic isNegative(input logic [15:0] v);
      isNegative = v[`DART_SIGN_BIT];
   endfunction

   logic        tickSel;
   logic [15:0] limit;

   // Selected interval tick for this element
   assign tickSel = coarseBase ? tickBus.coarseTick : tickBus.fineTick;
   assign limit = isNegative(targetCount) ? `DART_COUNT_ZERO : targetCount;

   // ----------------------------------------------------------------
   // Scan evaluation
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.wasRun = modeRun;
      // Intervals accumulate between scans, saturating at 255, so a scan of up to 255 intervals loses none
      if (tickSel && (st.pending != 8'hFF))
         next_st.pending = st.pending + `DART_PEND_ONE;
      // Runtime error on a negative target or elapsed value
      if (isNegative(targetCount) || isNegative(st.elapsed))
         next_st.error = 1'b1;
      // Leaving execute and trial freezes control flags and count and drops pending intervals, including across power loss
      if (!modeRun)
      begin
         next_st.pending = `DART_PEND_ZERO;
         if (!st.wasRun)
            next_st.resumed = 1'b0;
      end
      else if (!st.wasRun)
      begin
         // First cycle back in execute or trial: resolve on next scan
         next_st.resumed = 1'b1;
         next_st.pending = `DART_PEND_ZERO;
      end
      else if (scanStrobe)
      begin
         next_st.pending = (tickSel && !st.resumed) ? `DART_PEND_ONE : `DART_PEND_ZERO;
         next_st.rungPrev = rungTrue;
         next_st.resumed = 1'b0;
         next_st.active = rungTrue;
         unique case (behaviour)
            dart_pkg::DART_OFF_DELAY:
            begin
               if (st.resumed && st.running)
               begin
                  next_st.running = 1'b0;
                  next_st.active = rungTrue;
                  if (rungTrue)
                     next_st.elapsed = `DART_COUNT_ZERO;
                  else
                  begin
                     next_st.complete = 1'b0;
                     next_st.elapsed = limit;
                  end
               end
               else if (rungTrue)
               begin
                  next_st.elapsed = `DART_COUNT_ZERO;
                  next_st.complete = 1'b1;
                  next_st.running = 1'b0;
               end
               else if (st.complete)
               begin
                  // Counts on even when zone is inactive
                  next_st.elapsed = addCapped(st.elapsed, st.pending, limit);
                  if (next_st.elapsed >= limit)
                  begin
                     next_st.complete = 1'b0;
                     next_st.running = 1'b0;
                  end
                  else
                     next_st.running = 1'b1;
               end
               else
                  next_st.running = 1'b0;
            end
            dart_pkg::DART_RETENTIVE:
            begin
               if (rungTrue && zoneActive)
               begin
                  // Continues from the kept count after any pause
                  next_st.elapsed = addCapped(st.elapsed, st.resumed ? `DART_PEND_ZERO : st.pending, limit);
                  if (next_st.elapsed >= limit)
                     next_st.complete = 1'b1;
                  next_st.running = !next_st.complete;
               end
               else
               begin
                  next_st.active = 1'b0;
                  next_st.running = 1'b0;
               end
            end
            default:
            begin
               if (st.resumed && st.running)
                  next_st.elapsed = `DART_COUNT_ZERO;
               else if (rungTrue && zoneActive)
                  next_st.elapsed = addCapped(st.elapsed, st.pending, limit);
               if (rungTrue && zoneActive)
               begin
                  next_st.complete = next_st.elapsed >= limit;
                  next_st.running = !next_st.complete;
               end
               else
               begin
                  next_st.active = 1'b0;
                  next_st.elapsed = `DART_COUNT_ZERO;
                  next_st.complete = 1'b0;
                  next_st.running = 1'b0;
               end
            end
         endcase
         // Clear from a separate rung zeroes flags and count, except for an off-delay element
         if (clearCommand && (behaviour != dart_pkg::DART_OFF_DELAY))
         begin
            next_st.complete = 1'b0;
            next_st.running = 1'b0;
            next_st.active = 1'b0;
            next_st.elapsed = `DART_COUNT_ZERO;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // Element words
   // ----------------------------------------------------------------
   always_comb
   begin
      controlWord = 16'h0000;
      controlWord[`DART_BIT_ACTIVE] = st.active;
      controlWord[`DART_BIT_RUNNING] = st.running;
      controlWord[`DART_BIT_COMPLETE] = st.complete;
   end

   assign targetWord = targetCount;
   assign elapsedCount = st.elapsed;
   assign runtimeError = st.error;

endmodule

// ---- verification/dart_monitor.sv ----
// Port assertions for the timer element
// Assumes binding into dart_timer and one clock domain
`timescale 1ns/100ps
module dart_monitor #(
   parameter int FINE_CYCLES   = 4,
   parameter int COARSE_CYCLES = 400
)(
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset,
   // Mode and configuration
   input  wire dart_pkg::dart_mode_type  ctrlMode,
   input  wire logic                    powerGood,
   input  wire dart_pkg::dart_behav_type behaviour,
   input  wire logic [15:0]             targetCount,
   // Scan interface
   input  wire logic                    scanStrobe,
   input  wire logic                    rungTrue,
   input  wire logic                    zoneActive,
   input  wire logic                    clearCommand,
   // Element state
   input  wire logic [15:0]             controlWord,
   input  wire logic [15:0]             targetWord,
   input  wire logic [15:0]             elapsedCount,
   input  wire logic                    runtimeError
);
   // ----------------------------------------------------------------
   // Settled run mode and accepted scans
   // ----------------------------------------------------------------
   logic [3:0] okCnt;

   default clocking dart_cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // Cycles since run mode with power, covers synchroniser and resume
   always_ff @(posedge core_clk)
   begin
      if (reset || ctrlMode[1] || !powerGood)
         okCnt <= 4'h0;
      else if (okCnt != 4'hF)
         okCnt <= okCnt + 4'h1;
   end

   sequence s_take;
      scanStrobe && okCnt >= 4'h8;
   endsequence

   chk_target_copy: assert property (targetWord == targetCount)
      else $error("target word differs from target input");
   chk_spare_bits: assert property (controlWord[12:0] == 13'h0000)
      else $error("unused control bits set");
   chk_err_sticky: assert property (runtimeError |=> runtimeError)
      else $error("runtime error dropped");
   chk_err_cause: assert property (s_take ##0 targetCount[15] |=> runtimeError)
      else $error("negative target without error");
   chk_count_cap: assert property (s_take ##0 !targetCount[15] |=> elapsedCount <= $past(targetCount))
      else $error("elapsed count above target");
   chk_active_true: assert property (s_take ##0 (rungTrue && (zoneActive || behaviour == dart_pkg::DART_OFF_DELAY))
      |=> controlWord[15])
      else $error("active flag not set");
   chk_active_false: assert property (s_take ##0 !rungTrue |=> !controlWord[15])
      else $error("active flag not cleared");
   chk_run_excl: assert property (behaviour != dart_pkg::DART_OFF_DELAY |-> !(controlWord[14] && controlWord[13]))
      else $error("running and complete together");
   chk_on_false: assert property (s_take ##0 (!rungTrue && behaviour == dart_pkg::DART_ON_DELAY)
      |=> controlWord[15:13] == 3'h0 && elapsedCount == 16'h0000)
      else $error("on-delay not cleared by false rung");
   chk_off_true: assert property (s_take ##0 (rungTrue && behaviour == dart_pkg::DART_OFF_DELAY)
      |=> controlWord[15:13] == 3'h5 && elapsedCount == 16'h0000)
      else $error("off-delay true rung state wrong");
   chk_clear_zero: assert property (s_take ##0 (clearCommand && !rungTrue && behaviour != dart_pkg::DART_OFF_DELAY)
      |=> controlWord == 16'h0000 && elapsedCount == 16'h0000)
      else $error("clear left state behind");
   chk_ret_keep: assert property (s_take ##0 (!rungTrue && !clearCommand && behaviour == dart_pkg::DART_RETENTIVE)
      |=> $stable(elapsedCount) && controlWord[15:14] == 2'h0)
      else $error("retentive lost count on false rung");
   chk_hold_idle: assert property (!scanStrobe && okCnt >= 4'h8 |=> $stable(controlWord) && $stable(elapsedCount))
      else $error("state changed without a scan");
endmodule

bind dart_timer dart_monitor #(.FINE_CYCLES(FINE_CYCLES), .COARSE_CYCLES(COARSE_CYCLES)) i_monitor (
   .core_clk(core_clk), .reset(reset), .ctrlMode(ctrlMode), .powerGood(powerGood), .behaviour(behaviour),
   .targetCount(targetCount), .scanStrobe(scanStrobe), .rungTrue(rungTrue), .zoneActive(zoneActive),
   .clearCommand(clearCommand), .controlWord(controlWord), .targetWord(targetWord),
   .elapsedCount(elapsedCount), .runtimeError(runtimeError));

// ---- verification/dart_program_model.sv ----
// Controlling program model: presents one scan per request
// Assumes requests from the bench on the core clock
`timescale 1ns/100ps
module dart_program_model (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset,
   // Bench requests
   input  wire logic                    scanReq,
   input  wire logic                    progRung,
   input  wire logic                    progClear,
   input  wire logic                    progZone,
   input  wire dart_pkg::dart_behav_type behaviour,
   // Scan interface
   output logic                         scanStrobe,
   output logic                         rungTrue,
   output logic                         zoneActive,
   output logic                         clearCommand
);
   // ----------------------------------------------------------------
   // Scan driver
   // ----------------------------------------------------------------
   // Clear only from its own scan, never towards an off-delay element
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         scanStrobe   <= 1'b0;
         rungTrue     <= 1'b0;
         zoneActive   <= 1'b1;
         clearCommand <= 1'b0;
      end
      else
      begin
         scanStrobe   <= scanReq;
         clearCommand <= scanReq && progClear && behaviour != dart_pkg::DART_OFF_DELAY;
         if (scanReq)
         begin
            rungTrue   <= progRung;
            zoneActive <= progZone;
         end
      end
   end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the timer element
// Assumes the program model and bound checker; short timebase counts
`timescale 1ns/100ps
module tb;
   // ----------------------------------------------------------------
   // Signals, instances and helpers
   // ----------------------------------------------------------------
   logic                    core_clk, reset, powerGood, coarseBase, scanReq, progRung, progClear, progZone;
   logic                    scanStrobe, rungTrue, zoneActive, clearCommand, runtimeError;
   logic [15:0]             targetCount, controlWord, targetWord, elapsedCount, held;
   dart_pkg::dart_mode_type  ctrlMode;
   dart_pkg::dart_behav_type behaviour;
   int                      failures, num_checks, cycles;

   dart_program_model i_prog (.core_clk(core_clk), .reset(reset), .scanReq(scanReq), .progRung(progRung),
      .progClear(progClear), .progZone(progZone), .behaviour(behaviour), .scanStrobe(scanStrobe),
      .rungTrue(rungTrue), .zoneActive(zoneActive), .clearCommand(clearCommand));
   dart_timer #(.FINE_CYCLES(4), .COARSE_CYCLES(400)) i_dut (.core_clk(core_clk), .reset(reset),
      .ctrlMode(ctrlMode), .powerGood(powerGood), .behaviour(behaviour), .coarseBase(coarseBase),
      .targetCount(targetCount), .scanStrobe(scanStrobe), .rungTrue(rungTrue), .zoneActive(zoneActive),
      .clearCommand(clearCommand), .controlWord(controlWord), .targetWord(targetWord),
      .elapsedCount(elapsedCount), .runtimeError(runtimeError));

   // Clock and hang limit
   initial core_clk = 1'b0;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 10000)
      begin
         failures = failures + 1;
         test_done();
      end
   end

   task test_done();
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task cw(input logic [2:0] e);
      check("controlWord", controlWord, {e, 13'h0000});
   endtask
   task ec(input logic [15:0] e);
      check("elapsedCount", elapsedCount, e);
   endtask
   task lt(input logic [15:0] lim);
      check("elapsedBelow", {15'h0000, elapsedCount < lim}, 16'h0001);
   endtask
   // One scan through the program model; the answer has settled on return
   task scan(input logic r, input logic c);
      scanReq   <= 1'b1;
      progRung  <= r;
      progClear <= c;
      idle(1);
      scanReq <= 1'b0;
      idle(3);
   endtask
   task mode(input dart_pkg::dart_mode_type m, input logic p);
      ctrlMode  <= m;
      powerGood <= p;
      idle(10);
   endtask
   task rst(input dart_pkg::dart_behav_type b, input logic [15:0] t, input logic c);
      reset       <= 1'b1;
      behaviour   <= b;
      targetCount <= t;
      coarseBase  <= c;
      ctrlMode    <= dart_pkg::DART_EXECUTE;
      powerGood   <= 1'b1;
      scanReq     <= 1'b0;
      progRung    <= 1'b0;
      progClear   <= 1'b0;
      progZone    <= 1'b1;
      idle(20);
      reset <= 1'b0;
      idle(10);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      failures = 0;
      num_checks = 0;
      cycles = 0;
      // On-delay timing, capping and false rung
      rst(dart_pkg::DART_ON_DELAY, 16'h0014, 1'b0);
      check("targetWord", targetWord, 16'h0014);
      scan(1'b0, 1'b0);
      scan(1'b1, 1'b0);
      cw(3'h6);
      lt(16'h0014);
      idle(120);
      scan(1'b1, 1'b0);
      cw(3'h5);
      ec(16'h0014);
      scan(1'b0, 1'b0);
      cw(3'h0);
      ec(16'h0000);
      targetCount <= 16'h8000;
      scan(1'b1, 1'b0);
      check("runtimeError", {15'h0000, runtimeError}, 16'h0001);
      // On-delay interrupted by edit mode, resumed in trial mode
      rst(dart_pkg::DART_ON_DELAY, 16'h0014, 1'b0);
      scan(1'b0, 1'b0);
      scan(1'b1, 1'b0);
      idle(8);
      scan(1'b1, 1'b0);
      held = elapsedCount;
      mode(dart_pkg::DART_EDIT, 1'b1);
      idle(20);
      cw(3'h6);
      ec(held);
      mode(dart_pkg::DART_TRIAL, 1'b1);
      scan(1'b0, 1'b0);
      cw(3'h0);
      ec(16'h0000);
      // Off-delay with inactive control zone, then power loss
      rst(dart_pkg::DART_OFF_DELAY, 16'h000A, 1'b0);
      progZone <= 1'b0;
      scan(1'b1, 1'b0);
      cw(3'h5);
      ec(16'h0000);
      scan(1'b0, 1'b0);
      cw(3'h3);
      idle(60);
      scan(1'b0, 1'b0);
      cw(3'h0);
      ec(16'h000A);
      scan(1'b1, 1'b0);
      scan(1'b0, 1'b0);
      held = elapsedCount;
      mode(dart_pkg::DART_EXECUTE, 1'b0);
      cw(3'h3);
      ec(held);
      mode(dart_pkg::DART_EXECUTE, 1'b1);
      scan(1'b0, 1'b0);
      cw(3'h0);
      ec(16'h000A);
      // Retentive on the coarse timebase, fault halt and clear
      rst(dart_pkg::DART_RETENTIVE, 16'h0003, 1'b1);
      scan(1'b1, 1'b0);
      idle(100);
      scan(1'b1, 1'b0);
      cw(3'h6);
      lt(16'h0003);
      scan(1'b0, 1'b0);
      held = elapsedCount;
      cw(3'h0);
      ec(held);
      mode(dart_pkg::DART_FAULT_HALT, 1'b1);
      mode(dart_pkg::DART_EXECUTE, 1'b1);
      scan(1'b1, 1'b0);
      cw(3'h6);
      idle(1300);
      scan(1'b1, 1'b0);
      cw(3'h5);
      ec(16'h0003);
      scan(1'b0, 1'b0);
      cw(3'h1);
      ec(16'h0003);
      scan(1'b0, 1'b1);
      cw(3'h0);
      ec(16'h0000);
      test_done();
   end
endmodule
